// [cos_map.svh]
`ifndef COS_MAP_SVH
`define COS_MAP_SVH
`define COS_ADDR_W 8
`define COS_OFF_ENABLE_POLARITY 8'h20
`define COS_OFF_CHANNEL_CTRL 8'h24
`define COS_OFF_STAGE_CTRL 8'h28
`define COS_OFF_STATUS 8'h2C
`define COS_BIT_CHANNEL_ON 0
`define COS_BIT_PRIMARY_POLARITY 1
`define COS_BIT_COMP_OUT_ENABLE 2
`define COS_BIT_COMP_OUT_POLARITY 3
`define COS_BIT_MAIN_OUTPUT_GATE 0
`define COS_BIT_OFFSTATE_IDLE 1
`define COS_BIT_OFFSTATE_RUN 2
`define COS_BIT_PRIMARY_IDLE 3
`define COS_BIT_COMP_IDLE 4
`define COS_LOCK_LO 5
`define COS_LOCK_HI 6
`define COS_RESET_ENABLE_POLARITY 4'h0
`define COS_RESET_DIRECTION 2'h0
`endif

// [cos_pkg.sv]
package cos_pkg;
  typedef enum logic [1:0] {
    COS_DIR_OUTPUT = 2'b00,
    COS_DIR_INPUT_LINE1 = 2'b01,
    COS_DIR_RSVD2 = 2'b10,
    COS_DIR_RSVD3 = 2'b11
  } cos_dir_e;

  typedef enum logic [1:0] {
    COS_EDGE_RISING = 2'b00,
    COS_EDGE_FALLING = 2'b01,
    COS_EDGE_INVALID = 2'b10,
    COS_EDGE_BOTH = 2'b11
  } cos_edge_e;

  typedef struct packed {
    logic comp_out_polarity;
    logic comp_out_enable;
    logic primary_polarity;
    logic channel_on;
  } cos_enpol_s;

  typedef struct packed {
    logic [1:0] lock_level;
    logic complementary_idle_level;
    logic primary_idle_level;
    logic offstate_run_select;
    logic offstate_idle_select;
    logic main_output_gate;
  } cos_stage_s;

  typedef struct packed {
    logic primary_output_pin;
    logic primary_drive_enable;
    logic complementary_output_pin;
    logic complementary_drive_enable;
  } cos_pins_s;
endpackage

// [cos_output_stage.sv]
// Strobed register access was left to the implementer.
`include "cos_map.svh"

// Overview of operation
// - Complementary polarity bit 3 inverts complementary output, except with both on and run select
// - Lock 2/3 in output mode blocks complementary polarity
// - Complementary enable bit 2 gates complementary pin
// - Primary polarity bit 1 inverts primary output
// - Input mode: polarity pair selects capture edge
// - Lock 2/3 in output mode blocks primary polarity
// - Disabled output undriven, value 0, enable 0, except in idle off-state, which drives both
// - Only complementary on, run select off: reference xor complementary polarity
// - Only primary on, run select off: reference xor primary polarity
// - Both on, run select: primary is deadtime reference xor primary polarity, complementary is inverted reference
// - Direction 00 output, 01 input line 1
// - Channel on drives primary or permits capture
module cos_output_stage (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [`COS_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic reference_waveform,
  input wire logic reference_deadtime,
  input wire logic filtered_input_edge,
  output cos_pkg::cos_pins_s pins,
  output logic capture_pulse,
  output logic edge_config_invalid
);

  cos_pkg::cos_enpol_s enpol_r, enpol_nxt;
  cos_pkg::cos_stage_s stage_r, stage_nxt;
  cos_pkg::cos_dir_e dir_r, dir_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  cos_pkg::cos_pins_s pins_r, pins_nxt;
  logic in_meta_r, in_sync_r, in_prev_r;
  logic cap_r, cap_nxt;
  logic inval_r, inval_nxt;
  logic locked;
  logic rise, fall;

  function automatic logic [31:0] status_word(input cos_pkg::cos_pins_s p,
                                              input logic s);
    status_word = {27'h0000000, s, p};
  endfunction

  assign locked = (stage_r.lock_level >= 2'h2) && (dir_r == cos_pkg::COS_DIR_OUTPUT);

  // Register file
  always_comb begin
    enpol_nxt = enpol_r;
    stage_nxt = stage_r;
    dir_nxt = dir_r;
    rdata_nxt = 32'h00000000;
    if (reg_wr) begin
      unique case (reg_addr)
        `COS_OFF_ENABLE_POLARITY: begin
          enpol_nxt.channel_on = reg_wdata[`COS_BIT_CHANNEL_ON];
          enpol_nxt.comp_out_enable = reg_wdata[`COS_BIT_COMP_OUT_ENABLE];
          if (!locked) begin
            enpol_nxt.primary_polarity = reg_wdata[`COS_BIT_PRIMARY_POLARITY];
            enpol_nxt.comp_out_polarity = reg_wdata[`COS_BIT_COMP_OUT_POLARITY];
          end
        end
        `COS_OFF_CHANNEL_CTRL: begin
          // Direction only changes while the channel is off
          if (!enpol_r.channel_on) begin
            dir_nxt = cos_pkg::cos_dir_e'(reg_wdata[1:0]);
          end
        end
        `COS_OFF_STAGE_CTRL: begin
          stage_nxt.main_output_gate = reg_wdata[`COS_BIT_MAIN_OUTPUT_GATE];
          stage_nxt.offstate_idle_select = reg_wdata[`COS_BIT_OFFSTATE_IDLE];
          stage_nxt.offstate_run_select = reg_wdata[`COS_BIT_OFFSTATE_RUN];
          stage_nxt.primary_idle_level = reg_wdata[`COS_BIT_PRIMARY_IDLE];
          stage_nxt.complementary_idle_level = reg_wdata[`COS_BIT_COMP_IDLE];
          // Lock level can only be raised, never lowered, until reset
          if (reg_wdata[`COS_LOCK_HI:`COS_LOCK_LO] > stage_r.lock_level) begin
            stage_nxt.lock_level = reg_wdata[`COS_LOCK_HI:`COS_LOCK_LO];
          end
        end
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `COS_OFF_ENABLE_POLARITY: rdata_nxt = {28'h0000000, enpol_r};
        `COS_OFF_CHANNEL_CTRL: rdata_nxt = {30'h00000000, dir_r};
        `COS_OFF_STAGE_CTRL: rdata_nxt = {25'h0000000, stage_r};
        `COS_OFF_STATUS: rdata_nxt = status_word(pins_r, inval_r);
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      enpol_r <= `COS_RESET_ENABLE_POLARITY;
      stage_r <= 7'h00;
      dir_r <= cos_pkg::COS_DIR_OUTPUT;
      rdata_r <= 32'h00000000;
    end else begin
      enpol_r <= enpol_nxt;
      stage_r <= stage_nxt;
      dir_r <= dir_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Output stage
  always_comb begin
    pins_nxt = '0;
    if (dir_r != cos_pkg::COS_DIR_OUTPUT) begin
      pins_nxt = '0;
    end else if (stage_r.main_output_gate && !stage_r.offstate_run_select) begin
      // disabled outputs stay at zero with enable low
      if (enpol_r.channel_on) begin
        pins_nxt.primary_output_pin = reference_waveform ^ enpol_r.primary_polarity;
        pins_nxt.primary_drive_enable = 1'b1;
      end
      if (enpol_r.comp_out_enable) begin
        pins_nxt.complementary_output_pin =
          reference_waveform ^ enpol_r.comp_out_polarity;
        pins_nxt.complementary_drive_enable = 1'b1;
      end
    end else if (stage_r.main_output_gate && enpol_r.channel_on &&
                 enpol_r.comp_out_enable) begin
      pins_nxt.primary_output_pin = reference_deadtime ^ enpol_r.primary_polarity;
      pins_nxt.primary_drive_enable = 1'b1;
      pins_nxt.complementary_output_pin = ~reference_waveform;
      pins_nxt.complementary_drive_enable = 1'b1;
    end else if (stage_r.main_output_gate) begin
      // Run off-state: enabled outputs held at inactive level
      // Released outputs must read zero, so the level is masked by the enable
      pins_nxt.primary_output_pin = enpol_r.primary_polarity & enpol_r.channel_on;
      pins_nxt.primary_drive_enable = enpol_r.channel_on;
      pins_nxt.complementary_output_pin =
        enpol_r.comp_out_polarity & enpol_r.comp_out_enable;
      pins_nxt.complementary_drive_enable = enpol_r.comp_out_enable;
    end else if (stage_r.offstate_idle_select) begin
      pins_nxt.primary_output_pin = stage_r.primary_idle_level;
      pins_nxt.primary_drive_enable = 1'b1;
      pins_nxt.complementary_output_pin = stage_r.complementary_idle_level;
      pins_nxt.complementary_drive_enable = 1'b1;
    end
  end

  // Capture edge select
  assign rise = in_sync_r && !in_prev_r;
  assign fall = !in_sync_r && in_prev_r;

  always_comb begin
    cap_nxt = 1'b0;
    inval_nxt = 1'b0;
    if (dir_r == cos_pkg::COS_DIR_INPUT_LINE1) begin
      unique case (cos_pkg::cos_edge_e'({enpol_r.comp_out_polarity, enpol_r.primary_polarity}))
        cos_pkg::COS_EDGE_RISING: cap_nxt = rise;
        cos_pkg::COS_EDGE_FALLING: cap_nxt = fall;
        cos_pkg::COS_EDGE_BOTH: cap_nxt = rise | fall;
        cos_pkg::COS_EDGE_INVALID: inval_nxt = 1'b1;
      endcase
      cap_nxt = cap_nxt & enpol_r.channel_on;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pins_r <= '0;
      in_meta_r <= 1'b0;
      in_sync_r <= 1'b0;
      in_prev_r <= 1'b0;
      cap_r <= 1'b0;
      inval_r <= 1'b0;
    end else begin
      pins_r <= pins_nxt;
      in_meta_r <= filtered_input_edge;
      in_sync_r <= in_meta_r;
      in_prev_r <= in_sync_r;
      cap_r <= cap_nxt;
      inval_r <= inval_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign pins = pins_r;
  assign capture_pulse = cap_r;
  assign edge_config_invalid = inval_r;

endmodule

// [cos_output_stage_assertions.sv]
module cos_output_stage_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic filtered_input_edge,
  input wire cos_pkg::cos_pins_s pins,
  input wire logic capture_pulse,
  input wire logic edge_config_invalid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_read_quiet:
    assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  a_prim_released:
    assert property (!pins.primary_drive_enable |-> !pins.primary_output_pin)
    else $error("undriven primary not low");
  a_comp_released:
    assert property (!pins.complementary_drive_enable |-> !pins.complementary_output_pin)
    else $error("undriven complementary not low");
  a_capture_edge:
    assert property (capture_pulse |-> $past(filtered_input_edge, 3) != $past(filtered_input_edge, 4))
    else $error("capture without input edge");
  a_drive_settles:
    assert property ($changed({pins.primary_drive_enable, pins.complementary_drive_enable})
      |-> $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3))
    else $error("drive enable moved without a write");
  a_invalid_settles:
    assert property ($changed(edge_config_invalid)
      |-> $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3))
    else $error("edge flag moved without a write");
  a_capture_quiet:
    assert property (capture_pulse |-> pins == 4'h0)
    else $error("pins driven while capturing");
  a_invalid_quiet:
    assert property (edge_config_invalid |-> pins == 4'h0)
    else $error("pins driven in input mode");
endmodule

bind cos_output_stage cos_output_stage_chk cos_output_stage_chk_inst (.clk_sys, .rst_n, .reg_wr,
  .reg_rd, .reg_rdata, .filtered_input_edge, .pins, .capture_pulse, .edge_config_invalid);

// [cos_load_model.sv]
module cos_load_model (
  input wire cos_pkg::cos_pins_s pins,
  output logic primary_pad,
  output logic comp_pad
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-downs on the loads hold a released pad low
  assign primary_pad = pins.primary_drive_enable & pins.primary_output_pin;
  assign comp_pad = pins.complementary_drive_enable & pins.complementary_output_pin;
endmodule

// [cos_output_stage_bench.sv]
module cos_output_stage_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic ref_w = 1'b0;
  logic ref_d = 1'b0;
  logic fie = 1'b0;
  cos_pkg::cos_pins_s pins;
  logic capture_pulse;
  logic edge_config_invalid;
  logic primary_pad;
  logic comp_pad;
  int err_total = 0;
  int comparisons = 0;
  int nr;
  int nf;
  always #5 clk_sys = ~clk_sys;
  cos_output_stage cos_output_stage_inst (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .reference_waveform(ref_w), .reference_deadtime(ref_d),
    .filtered_input_edge(fie), .pins, .capture_pulse, .edge_config_invalid);
  cos_load_model cos_load_model_inst (.pins, .primary_pad, .comp_pad);
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (err_total == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    check("rdata", reg_rdata, exp);
  endtask
  task automatic pv(logic r, logic d, logic [3:0] m, logic [3:0] e);
    @(posedge clk_sys);
    ref_w <= r;
    ref_d <= d;
    repeat (3) @(posedge clk_sys);
    check("pins", {28'h0, pins & m}, {28'h0, e});
    check("pads", {30'h0, primary_pad, comp_pad}, {30'h0, e[3] & e[2], e[1] & e[0]});
  endtask
  task automatic cnt(logic v, output int n);
    @(posedge clk_sys);
    fie <= v;
    n = 0;
    repeat (8) begin
      @(posedge clk_sys);
      if (capture_pulse === 1'b1) n++;
    end
  endtask
  task automatic t_outputs();
    wr(8'h28, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(8'h20, {30'h0, i[1], 1'b1});
      pv(i[0], i[0], 4'hF, {i[0] ^ i[1], 3'b100});
      wr(8'h20, {28'h0, i[1], 3'b100});
      pv(i[0], i[0], 4'hF, {2'b00, i[0] ^ i[1], 1'b1});
    end
    wr(8'h20, 32'h0);
    pv(1'b1, 1'b1, 4'hF, 4'h0);
    wr(8'h28, 32'h5);
    wr(8'h20, 32'h7);
    for (int i = 0; i < 4; i++) pv(i[0], i[1], 4'hF, {~i[1], 1'b1, ~i[0], 1'b1});
    wr(8'h20, 32'h1);
    pv(1'b1, 1'b1, 4'hF, 4'h4);
    wr(8'h20, 32'hB);
    pv(1'b1, 1'b1, 4'hF, 4'hC);
    wr(8'h28, 32'hA);
    pv(1'b1, 1'b1, 4'hF, 4'hD);
    rd(8'h2C, 32'hD);
    wr(8'h28, 32'h0);
    pv(1'b1, 1'b1, 4'hF, 4'h0);
  endtask
  task automatic t_input();
    wr(8'h20, 32'h0);
    wr(8'h24, 32'h1);
    pv(1'b1, 1'b1, 4'hF, 4'h0);
    for (int c = 0; c < 4; c++) begin
      wr(8'h20, {28'h0, c[1], 1'b0, c[0], 1'b1});
      cnt(1'b1, nr);
      cnt(1'b0, nf);
      check("invalid", {31'h0, edge_config_invalid}, {31'h0, c == 2});
      check("rise", nr, 32'(c == 0 || c == 3));
      check("fall", nf, 32'(c == 1 || c == 3));
      rd(8'h2C, {27'h0, c == 2, 4'h0});
    end
    wr(8'h20, 32'h0);
    cnt(1'b1, nr);
    check("gated", nr, 0);
  endtask
  task automatic t_lock();
    wr(8'h28, 32'h41);
    wr(8'h20, 32'hA);
    rd(8'h20, 32'hA);
    wr(8'h20, 32'h0);
    wr(8'h24, 32'h0);
    wr(8'h20, 32'hF);
    rd(8'h20, 32'h5);
    rd(8'h30, 32'h0);
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(8'h20, 32'h0);
    t_outputs();
    t_input();
    t_lock();
    stop_test();
  end
  initial begin
    #100000;
    err_total++;
    stop_test();
  end
endmodule
